/* File: src/watchdog_map.vh */
`ifndef WATCHDOG_MAP_VH
`define WATCHDOG_MAP_VH

// register indexes; byte address is four times the index
`define IDX_CLEAR 16'hFFFF
`define IDX_CONFIG 16'h000E
`define IDX_CAUSE 16'h0010
`define IDX_STATUS 16'h0011

// configuration latch fields
`define CFG_DISABLE 0
`define CFG_STOP_EN 1
`define CFG_RATE 2
`define CFG_W 3
`define CFG_RESET 3'h0

// reset cause fields
`define CAUSE_WDOG 0
`define CAUSE_ILLOP 1

// chain layout: prescaler bits 11..0, counter above them
`define PRE_W 12
`define CNT_W 6
`define CHAIN_W 18
`define CLR_LO 4
`define SHORT_TOP 13

// timing in crystal cycles
`define RST_PULSE_CYC 6'h20
`define POR_DELAY_CYC 13'h1000

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: src/runaway_code_watchdog.v */
`timescale 1ns/1ns
`default_nettype none
`include "watchdog_map.vh"

module runaway_code_watchdog #(
  parameter ADDR_W = 18
) (
  input wire clk,
  input wire nrst,
  // register bus
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // core side
  input wire [7:0] reset_vector_low,
  input wire cpu_clear_wr,
  input wire vector_fetch,
  input wire stop_exec,
  input wire stop_mode,
  input wire internal_reset,
  input wire monitor_mode,
  input wire break_active,
  input wire irq_test_voltage_level,
  input wire rst_test_voltage_level,
  // reset pin and reset requests
  output reg rst_pin_out,
  output reg rst_pin_oe_n,
  output reg watchdog_reset_req,
  output reg illegal_opcode_reset
);

  // aligned word index of a byte address
  function [15:0] word_idx;
    input [ADDR_W-1:0] a;
    begin
      word_idx = a[17:2];
    end
  endfunction

  // counter chain: prescaler low, counter high
  reg [`CHAIN_W-1:0] chain_q;
  reg [`CHAIN_W-1:0] chain_d;
  // pin pulse and power-up counters
  reg [5:0] pulse_q;
  reg [12:0] por_q;
  // configuration latch and cause flags
  reg [`CFG_W-1:0] cfg_q;
  reg cfg_locked_q;
  reg [1:0] cause_q;
  reg aw_held_q;
  reg w_held_q;
  // write halves held until both have arrived
  reg [ADDR_W-1:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;

  // read view of one word; the clear location shows the vector byte
  function [31:0] rd_word;
    input [15:0] idx;
    begin
      case (idx)
        `IDX_CLEAR: rd_word = {24'h000000, reset_vector_low};
        `IDX_CONFIG: rd_word = {29'h00000000, cfg_q};
        `IDX_CAUSE: rd_word = {30'h00000000, cause_q};
        `IDX_STATUS: rd_word = {14'h0000, chain_q};
        default: rd_word = 32'h00000000;
      endcase
    end
  endfunction

  // word indexes that answer; anything else gets a slave error
  function idx_mapped;
    input [15:0] idx;
    begin
      idx_mapped = (idx == `IDX_CLEAR) | (idx == `IDX_CONFIG) |
        (idx == `IDX_CAUSE) | (idx == `IDX_STATUS);
    end
  endfunction

  // power-up hold-off ends after 4096 cycles
  wire por_done = (por_q == `POR_DELAY_CYC);
  // latch fields seen by the counter and the stop opcode check
  wire rate_short = cfg_q[`CFG_RATE];
  wire stop_en = cfg_q[`CFG_STOP_EN];
  // monitor and break suspension come straight from the pins
  wire suspended = cfg_q[`CFG_DISABLE] |
    (monitor_mode & (irq_test_voltage_level | rst_test_voltage_level)) |
    (break_active & rst_test_voltage_level);
  wire pulsing = (pulse_q != 6'h00);

  // bus write goes out in the cycle both halves are present
  wire aw_now = aw_held_q | s_axi_awvalid;
  wire w_now = w_held_q | s_axi_wvalid;
  wire wr_fire = aw_now & w_now & ~s_axi_bvalid;
  // a parked half wins over the live channel
  wire [ADDR_W-1:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
  wire [15:0] wr_idx = word_idx(wr_addr);
  // decode of the word being written
  wire wr_clear = wr_fire & (wr_idx == `IDX_CLEAR);
  wire wr_config = wr_fire & (wr_idx == `IDX_CONFIG);
  wire wr_cause = wr_fire & (wr_idx == `IDX_CAUSE);
  wire wr_mapped = idx_mapped(wr_idx);

  // each write half ready while that half is not parked and no response is pending; read ready while no read data is pending
  assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // handshake strobes of the bus channels
  wire ar_fire = s_axi_arvalid & s_axi_arready;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire b_done = s_axi_bvalid & s_axi_bready;

  // any write lands, whatever the data, same cycle
  wire clear_evt = wr_clear | cpu_clear_wr;
  // all-ones detectors; the short period ends when bits 12..4 are full
  wire top_short = &chain_q[`SHORT_TOP-1:`CLR_LO];
  wire top_long = &chain_q[`CHAIN_W-1:`CLR_LO];
  wire expire = ~suspended & ~stop_mode & ~pulsing & por_done &
    (rate_short ? top_short : top_long);

  // pin goes low on the expiry edge and lets go after the last pulse cycle
  wire pulse_last = (pulse_q == 6'h01);
  wire pin_low = expire | (pulsing & ~pulse_last);
  // a stop opcode that the latch forbids
  wire illop_evt = stop_exec & ~stop_en;
  // counting waits out stop, suspension, power-up hold-off and the pulse
  wire count_en = ~stop_mode & ~suspended & por_done & ~pulsing;
  // prescaler-only clears
  wire pre_clear = stop_mode | stop_exec | vector_fetch | ~por_done;
  // whole-chain clears; restart from zero keeps a full period after enable
  wire chain_zero = internal_reset | pulsing | suspended | expire;

  // counter chain on the crystal clock; wait mode has no input here so it counts on
  always @* begin
    chain_d = chain_q;
    // one crystal cycle counted
    if (count_en) begin
      chain_d = chain_q + 18'h00001;
    end
    // software service keeps the low four prescaler bits
    if (clear_evt) begin
      chain_d[`CHAIN_W-1:`CLR_LO] = {(`CHAIN_W-`CLR_LO){1'b0}};
    end
    // stop, vector fetch and power-up hold the prescaler clear
    if (pre_clear) begin
      chain_d[`PRE_W-1:0] = {`PRE_W{1'b0}};
    end
    // zeroing last so it beats every other change
    if (chain_zero) begin
      chain_d = {`CHAIN_W{1'b0}};
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chain_q <= {`CHAIN_W{1'b0}};
    end else begin
      chain_q <= chain_d;
    end
  end

  // power-up delay before the prescaler is released
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      por_q <= 13'h0000;
    end else if (!por_done) begin
      por_q <= por_q + 13'h0001;
    end
  end

  // reset pin pulse; only a reset, never an interrupt
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pulse_q <= 6'h00;
      rst_pin_out <= 1'b1;
      rst_pin_oe_n <= 1'b1;
      watchdog_reset_req <= 1'b0;
    end else begin
      if (expire) begin
        pulse_q <= `RST_PULSE_CYC;
      end else if (pulsing) begin
        pulse_q <= pulse_q - 6'h01;
      end
      // open-drain: data stays low, the enable does the work
      rst_pin_out <= 1'b0;
      // pin and request share one term so they cannot drift apart
      rst_pin_oe_n <= ~pin_low;
      watchdog_reset_req <= pin_low;
    end
  end

  // stop opcode with stop disabled becomes an illegal opcode reset
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      illegal_opcode_reset <= 1'b0;
    end else begin
      illegal_opcode_reset <= illop_evt;
    end
  end

  // configuration latch takes the first lane 0 write after reset only
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= `CFG_RESET;
      cfg_locked_q <= 1'b0;
    end else if (wr_config & ~cfg_locked_q & (wr_strb_lo(1'b1))) begin
      cfg_q <= wr_data[`CFG_W-1:0];
      cfg_locked_q <= 1'b1;
    end
  end

  // low byte lane carries every narrow register
  function wr_strb_lo;
    input dummy;
    begin
      wr_strb_lo = dummy & (w_held_q ? wstrb_q[0] : s_axi_wstrb[0]);
    end
  endfunction

  // reset cause: hardware set wins over write-one-to-clear
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cause_q <= 2'h0;
    end else begin
      // software clear through lane 0
      if (wr_cause & wr_strb_lo(1'b1)) begin
        cause_q <= cause_q & ~wr_data[1:0];
      end
      if (expire) begin
        cause_q[`CAUSE_WDOG] <= 1'b1;
      end
      if (illop_evt) begin
        cause_q[`CAUSE_ILLOP] <= 1'b1;
      end
    end
  end

  // write channel: hold each half until both arrive
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= {ADDR_W{1'b0}};
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      // both halves present: issue the response
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else begin
        // park whichever half came first
        if (aw_take) begin
          aw_held_q <= 1'b1;
          awaddr_q <= s_axi_awaddr;
        end
        if (w_take) begin
          w_held_q <= 1'b1;
          wdata_q <= s_axi_wdata;
          wstrb_q <= s_axi_wstrb;
        end
        // response handshake
        if (b_done) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // read channel; the clear location shows the vector byte, not state
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word(word_idx(s_axi_araddr));
      s_axi_rresp <= idx_mapped(word_idx(s_axi_araddr)) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready) begin // response stands until taken
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // runaway_code_watchdog
`default_nettype wire

/* File: dv/runaway_code_watchdog_props.sv */
`timescale 1ns/1ns
`default_nettype none
module watchdog_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic stop_mode,
  input wire logic cpu_clear_wr,
  input wire logic monitor_mode,
  input wire logic break_active,
  input wire logic irq_test_voltage_level,
  input wire logic rst_test_voltage_level,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe_n,
  input wire logic watchdog_reset_req,
  input wire logic illegal_opcode_reset
);
  // any of the test-voltage suspend conditions
  wire susp = monitor_mode && (irq_test_voltage_level || rst_test_voltage_level)
    || break_active && rst_test_voltage_level;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // pin low for exactly 32 cycles, then released
  sequence s_low8;
    (!rst_pin_oe_n)[*8];
  endsequence
  sequence s_pulse;
    s_low8 ##1 s_low8 ##1 s_low8 ##1 s_low8 ##1 rst_pin_oe_n;
  endsequence
  AST_PULSE_LEN: assert property ($fell(rst_pin_oe_n) |-> s_pulse) else $error("bad pulse");
  AST_REQ_PIN: assert property (watchdog_reset_req == !rst_pin_oe_n) else $error("req");
  AST_PIN_DATA: assert property ($past(nrst) |-> !rst_pin_out) else $error("pin data");
  // two cycles of margin: expiry may already be registered
  AST_SUSPEND: assert property ($past(susp, 2) && $past(susp) |-> !$fell(rst_pin_oe_n))
    else $error("expiry while suspended");
  AST_STOP: assert property ($past(stop_mode, 2) && $past(stop_mode) |-> !$fell(rst_pin_oe_n))
    else $error("expiry in stop");
  AST_CLEAR: assert property (cpu_clear_wr |-> ##2 (!$fell(rst_pin_oe_n))[*8])
    else $error("expiry after clear");
  AST_ILLOP: assert property (illegal_opcode_reset |=> !illegal_opcode_reset)
    else $error("illop width");
  AST_RD_READY: assert property (s_axi_arready == !s_axi_rvalid) else $error("arready");
endmodule // watchdog_props
bind runaway_code_watchdog watchdog_props u_props (
  .clk(clk),
  .nrst(nrst),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .stop_mode(stop_mode),
  .cpu_clear_wr(cpu_clear_wr),
  .monitor_mode(monitor_mode),
  .break_active(break_active),
  .irq_test_voltage_level(irq_test_voltage_level),
  .rst_test_voltage_level(rst_test_voltage_level),
  .rst_pin_out(rst_pin_out),
  .rst_pin_oe_n(rst_pin_oe_n),
  .watchdog_reset_req(watchdog_reset_req),
  .illegal_opcode_reset(illegal_opcode_reset)
);
`default_nettype wire

/* File: dv/cpu_side_model.sv */
`timescale 1ns/1ns
`default_nettype none
module cpu_side_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic kick,
  input wire logic [7:0] vec,
  output logic [7:0] reset_vector_low,
  output logic cpu_clear_wr,
  output logic vector_fetch
);
  logic fetched_q;
  // one vector fetch as the core leaves reset; clear writes follow kick
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fetched_q <= 1'b0;
      vector_fetch <= 1'b0;
      cpu_clear_wr <= 1'b0;
    end else begin
      fetched_q <= 1'b1;
      vector_fetch <= !fetched_q;
      cpu_clear_wr <= kick;
    end
  end
  assign reset_vector_low = vec;
endmodule // cpu_side_model
`default_nettype wire

/* File: dv/runaway_code_watchdog_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module runaway_code_watchdog_tb_top;
  logic clk = 1'b0, nrst = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, kick = 1'b0;
  logic [17:0] s_axi_awaddr = 18'h0, s_axi_araddr = 18'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] vec = 8'h0, reset_vector_low;
  logic cpu_clear_wr, vector_fetch, stop_exec = 1'b0, stop_mode = 1'b0, internal_reset = 1'b0;
  logic monitor_mode = 1'b0, break_active = 1'b0, irq_test_voltage_level = 1'b0;
  logic rst_test_voltage_level = 1'b0, rst_pin_out, rst_pin_oe_n, watchdog_reset_req;
  logic illegal_opcode_reset, pa, pw;
  int bad_count = 0, tests_run = 0, n;
  runaway_code_watchdog dut (
    .clk(clk),
    .nrst(nrst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .reset_vector_low(reset_vector_low),
    .cpu_clear_wr(cpu_clear_wr),
    .vector_fetch(vector_fetch),
    .stop_exec(stop_exec),
    .stop_mode(stop_mode),
    .internal_reset(internal_reset),
    .monitor_mode(monitor_mode),
    .break_active(break_active),
    .irq_test_voltage_level(irq_test_voltage_level),
    .rst_test_voltage_level(rst_test_voltage_level),
    .rst_pin_out(rst_pin_out),
    .rst_pin_oe_n(rst_pin_oe_n),
    .watchdog_reset_req(watchdog_reset_req),
    .illegal_opcode_reset(illegal_opcode_reset)
  );
  cpu_side_model cpu (
    .clk(clk),
    .nrst(nrst),
    .kick(kick),
    .vec(vec),
    .reset_vector_low(reset_vector_low),
    .cpu_clear_wr(cpu_clear_wr),
    .vector_fetch(vector_fetch)
  );
  always #10 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // a used-up bound counts as a mismatch and ends the run
  task automatic guard(input int lim);
    if (n >= lim) begin
      bad_count++;
      end_of_test;
    end
  endtask
  task automatic wr(input logic [17:0] a, input logic [31:0] v);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    for (n = 0; (pa || pw) && n < 99; n++) begin
      @(posedge clk);
      if (pa && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (pw && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    // response is taken at the edge where it is seen
    for (; n < 99; n++) begin
      @(posedge clk);
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    guard(99);
  endtask
  task automatic rd(input logic [17:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) break;
    end
    s_axi_arvalid <= 1'b0;
    for (; n < 99; n++) begin
      @(posedge clk);
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    rr = s_axi_rresp;
    guard(99);
  endtask
  initial begin
    void'($urandom(32'hF714BD25));
    vec <= 8'($urandom);
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    wr(18'h38, 32'h4);
    wr(18'h38, 32'h1);
    rd(18'h38);
    check(d, 32'h4);
    rd(18'h3FFFC);
    check(d[7:0], vec);
    rd(18'h100);
    check(rr, 2'h2);
    stop_exec <= 1'b1;
    @(posedge clk);
    stop_exec <= 1'b0;
    @(negedge clk);
    check(illegal_opcode_reset, 1'b1);
    // past the power-on hold, a clear starts one short period
    repeat (4150 + $urandom % 100) @(posedge clk);
    kick <= 1'b1;
    @(posedge clk);
    kick <= 1'b0;
    for (n = 0; n < 9000 && rst_pin_oe_n !== 1'b0; n++) @(negedge clk);
    check(n >= 8155 && n <= 8185, 1'b1);
    for (n = 0; n < 99 && rst_pin_oe_n === 1'b0; n++) @(negedge clk);
    check(n, 32);
    rd(18'h40);
    check(d[0], 1'b1);
    wr(18'h40, 32'h1);
    rd(18'h40);
    check(d[0], 1'b0);
    // internal reset zeroes the whole chain; status shows it restarting
    internal_reset <= 1'b1;
    @(posedge clk);
    internal_reset <= 1'b0;
    rd(18'h44);
    check(d[17:0] < 18'h8, 1'b1);
    monitor_mode <= 1'b1;
    irq_test_voltage_level <= 1'b1;
    for (n = 0; n < 9000 && rst_pin_oe_n !== 1'b0; n++) begin
      @(posedge clk);
      if (n == 4500) begin
        monitor_mode <= 1'b0;
        break_active <= 1'b1;
        rst_test_voltage_level <= 1'b1;
        stop_mode <= 1'b1;
      end
    end
    check(n, 9000);
    // second reset: a disabled watchdog never expires
    break_active <= 1'b0;
    rst_test_voltage_level <= 1'b0;
    irq_test_voltage_level <= 1'b0;
    stop_mode <= 1'b0;
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    wr(18'h38, 32'h5);
    for (n = 0; n < 13000 && rst_pin_oe_n !== 1'b0; n++) @(posedge clk);
    check(n, 13000);
    end_of_test;
  end
endmodule // runaway_code_watchdog_tb_top
`default_nettype wire
